// file: logic/ping_tone_pkg.sv
package ping_tone_pkg;
   // ==========================================
   // Command kinds
   typedef enum logic [2:0] {
      CMD_NONE,
      CMD_WAKE,
      CMD_SLEEP_EXIT,
      CMD_SHUTDOWN,
      CMD_HARD_RESET,
      CMD_UART_CLEAR
   } cmd_kind_t;

   // ==========================================
   // Timing, in 40 ns clock cycles
   localparam int CLK_PERIOD_NS = 40;
   localparam int PING_CLR_MIN = 4;
   localparam int PING_WAKE_MIN = 8;
   localparam int PING_S2A_MIN = 16;
   localparam int PING_SHDN_MIN = 32;
   localparam int PING_HRST_MIN = 64;
   localparam int PING_MAX = 128;
   localparam int COUPLET_HALF = 2;
   localparam int TONE_TX_COUPLETS = 12;
   localparam int TONE_DET_COUPLETS = 8;
   // Quiet cycles that close one run of couplets, and that close a whole tone
   localparam int TONE_RUN_GAP = 4;
   localparam int TONE_END_GAP = 32;
   localparam int CNT_W = 8;
   localparam int HRST_HOLD_US = 1;
   localparam int HRST_HOLD_CYC = (HRST_HOLD_US * 1000) / CLK_PERIOD_NS;

   // Run counts identifying each tone; an extra burst is distinguished by length
   localparam int TONE_WAKE_LEN = 1;
   localparam int TONE_S2A_LEN = 2;
   localparam int TONE_SHDN_LEN = 3;
   localparam int TONE_HRST_LEN = 4;
   localparam int TONE_HB_LEN = 5;
   localparam int TONE_FAULT_LEN = 6;
endpackage : ping_tone_pkg

// file: logic/vertical_link_if.sv
`timescale 1ns/1ns
// Differential vertical link plus host receive line
interface vertical_link_if;
   logic rx_line;
   logic pos_couplet;
   logic neg_couplet;
   logic tone_group_id;
   modport device (input rx_line, input pos_couplet, input neg_couplet, input tone_group_id);
   modport partner (output rx_line, output pos_couplet, output neg_couplet, output tone_group_id);
endinterface : vertical_link_if

// file: logic/ping_tone_device.sv
`timescale 1ns/1ns

// Operation
// - Host ping is high, low, high
// - Ping kind chosen by low duration
// - Ping detection only in base device
// - Recognise wake, exit, shutdown, hard reset pings
// - Clear pulse clears the UART engine
// - Tone is same-polarity couplet burst
// - Transmit couplets exceed detect couplets
// - Stack recognises four matching tones
// - Heartbeat and fault tones only in sleep
// - Wake received forwards a wake tone
// - Sleep-exit received forwards sleep-exit tone
// - Forwarding follows the direction-select bit
// - Detect tones on either vertical port
// - Base device uses pings, not tones
// - Software bits emit matching tones
// - Host wakes chain via base ping
// - Shutdown not regenerated
// - Hard reset not forwarded
// - Neighbour issues recovery tones on request
// - Wake while active causes digital reset
// - Hard reset holds blocks off for HRST_HOLD_CYC cycles, then releases them
// - Sleep exit resets UART, no digital reset
module ping_tone_device import ping_tone_pkg::*; #(
   parameter int PING_CLR_MIN_P = PING_CLR_MIN,
   parameter int PING_WAKE_MIN_P = PING_WAKE_MIN,
   parameter int PING_S2A_MIN_P = PING_S2A_MIN,
   parameter int PING_SHDN_MIN_P = PING_SHDN_MIN,
   parameter int PING_HRST_MIN_P = PING_HRST_MIN,
   parameter int TONE_TX_P = TONE_TX_COUPLETS,
   parameter int TONE_DET_P = TONE_DET_COUPLETS
) (
   input wire logic sys_clk_in,
   input wire logic srst_in,
   input wire logic clk_en_in,
   input wire logic is_base_in,
   input wire logic in_sleep_in,
   input wire logic in_active_in,
   input wire logic dir_sel_in,
   input wire logic emit_wake_tone_cmd_in,
   input wire logic emit_sleep_exit_tone_cmd_in,
   input wire logic emit_shutdown_tone_cmd_in,
   input wire logic emit_hard_reset_tone_cmd_in,
   input wire logic emit_heartbeat_in,
   input wire logic emit_fault_tone_in,
   input wire logic hi_pos_in,
   input wire logic hi_neg_in,
   input wire logic lo_pos_in,
   input wire logic lo_neg_in,
   input wire logic rx_in,
   output logic hi_pos_out,
   output logic hi_neg_out,
   output logic lo_pos_out,
   output logic lo_neg_out,
   output logic wake_pulse_out,
   output logic sleep_exit_pulse_out,
   output logic shutdown_pulse_out,
   output logic hard_reset_pulse_out,
   output logic uart_clear_pulse_out,
   output logic digital_reset_pulse_out,
   output logic heartbeat_seen_pulse_out,
   output logic fault_tone_seen_pulse_out,
   output logic blocks_off_out
);
   // ==========================================
   // Ping low-time measurement
   logic rx_d_reg;
   logic [CNT_W-1:0] low_cnt_reg;
   cmd_kind_t ping_kind;
   logic ping_end;

   assign ping_end = rx_in && !rx_d_reg && is_base_in;
   always_comb begin
      ping_kind = CMD_NONE;
      if (low_cnt_reg >= CNT_W'(PING_HRST_MIN_P)) ping_kind = CMD_HARD_RESET;
      else if (low_cnt_reg >= CNT_W'(PING_SHDN_MIN_P)) ping_kind = CMD_SHUTDOWN;
      else if (low_cnt_reg >= CNT_W'(PING_S2A_MIN_P)) ping_kind = CMD_SLEEP_EXIT;
      else if (low_cnt_reg >= CNT_W'(PING_WAKE_MIN_P)) ping_kind = CMD_WAKE;
      else if (low_cnt_reg >= CNT_W'(PING_CLR_MIN_P)) ping_kind = CMD_UART_CLEAR;
   end

   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         rx_d_reg <= 1'b1;
         low_cnt_reg <= '0;
      end else if (clk_en_in) begin
         rx_d_reg <= rx_in;
         if (rx_in) low_cnt_reg <= '0;
         else if (low_cnt_reg != CNT_W'(PING_MAX)) low_cnt_reg <= low_cnt_reg + 1'b1;
      end
   end

   // ==========================================
   // Tone receivers: count couplets of each polarity on both ports
   logic [1:0] pol_in;
   logic [1:0] pol_d_reg;
   logic [1:0] run_pol_reg;
   logic couplet_start;
   logic [CNT_W-1:0] burst_cnt_reg;
   logic [CNT_W-1:0] gap_cnt_reg;
   logic [CNT_W-1:0] tone_len_reg;
   logic any_pulse;

   // Either port, whatever the direction bit says
   assign pol_in = {hi_neg_in | lo_neg_in, hi_pos_in | lo_pos_in};
   assign any_pulse = (pol_in != 2'b00) && !is_base_in;
   // Count couplet starts, not high cycles, so the detect threshold is in couplets
   assign couplet_start = any_pulse && pol_in != 2'b11 && pol_d_reg == 2'b00;
   // A tone is a run of same-polarity couplets; a tone code is the number of runs
   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         pol_d_reg <= 2'b00;
         run_pol_reg <= 2'b00;
         burst_cnt_reg <= '0;
         gap_cnt_reg <= '0;
         tone_len_reg <= '0;
      end else if (clk_en_in) begin
         pol_d_reg <= pol_in;
         if (any_pulse && pol_in != 2'b11) begin
            gap_cnt_reg <= '0;
         end else if (gap_cnt_reg != '1) begin
            gap_cnt_reg <= gap_cnt_reg + 1'b1;
         end
         if (couplet_start) begin
            run_pol_reg <= pol_in;
            // A polarity change inside a run starts the count again
            if (burst_cnt_reg != '0 && pol_in != run_pol_reg) burst_cnt_reg <= CNT_W'(1);
            else burst_cnt_reg <= burst_cnt_reg + 1'b1;
         end
         if (burst_cnt_reg >= CNT_W'(TONE_DET_P) && gap_cnt_reg == CNT_W'(TONE_RUN_GAP)) begin
            tone_len_reg <= tone_len_reg + 1'b1;
            burst_cnt_reg <= '0;
         end else if (gap_cnt_reg == CNT_W'(TONE_RUN_GAP)) begin
            burst_cnt_reg <= '0;
         end
         if (gap_cnt_reg == CNT_W'(TONE_END_GAP)) tone_len_reg <= '0;
      end
   end

   cmd_kind_t tone_kind;
   logic tone_done;
   assign tone_done = (gap_cnt_reg == CNT_W'(TONE_END_GAP)) && (tone_len_reg != '0);
   always_comb begin
      case (tone_len_reg)
         CNT_W'(TONE_WAKE_LEN): tone_kind = CMD_WAKE;
         CNT_W'(TONE_S2A_LEN): tone_kind = CMD_SLEEP_EXIT;
         CNT_W'(TONE_SHDN_LEN): tone_kind = CMD_SHUTDOWN;
         CNT_W'(TONE_HRST_LEN): tone_kind = CMD_HARD_RESET;
         default: tone_kind = CMD_NONE;
      endcase
   end

   // ==========================================
   // Command pulses, one cycle each
   cmd_kind_t cmd;
   assign cmd = ping_end ? ping_kind : (tone_done ? tone_kind : CMD_NONE);
   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         wake_pulse_out <= 1'b0;
         sleep_exit_pulse_out <= 1'b0;
         shutdown_pulse_out <= 1'b0;
         hard_reset_pulse_out <= 1'b0;
         uart_clear_pulse_out <= 1'b0;
         digital_reset_pulse_out <= 1'b0;
         heartbeat_seen_pulse_out <= 1'b0;
         fault_tone_seen_pulse_out <= 1'b0;
      end else if (clk_en_in) begin
         // Pulses hold like all other state while the clock enable is low
         wake_pulse_out <= clk_en_in && cmd == CMD_WAKE;
         sleep_exit_pulse_out <= clk_en_in && cmd == CMD_SLEEP_EXIT;
         shutdown_pulse_out <= clk_en_in && cmd == CMD_SHUTDOWN;
         hard_reset_pulse_out <= clk_en_in && cmd == CMD_HARD_RESET;
         // Sleep exit clears only the UART; wake resets the digital core
         uart_clear_pulse_out <= clk_en_in && (cmd == CMD_UART_CLEAR || cmd == CMD_SLEEP_EXIT);
         // From shutdown the power-up itself resets the core, so no pulse is needed
         digital_reset_pulse_out <= clk_en_in && cmd == CMD_WAKE && (in_active_in || in_sleep_in);
         heartbeat_seen_pulse_out <= clk_en_in && tone_done && in_sleep_in
                                     && tone_len_reg == CNT_W'(TONE_HB_LEN);
         fault_tone_seen_pulse_out <= clk_en_in && tone_done && in_sleep_in
                                      && tone_len_reg == CNT_W'(TONE_FAULT_LEN);
      end
   end

   // ==========================================
   // Hard reset hold timer
   logic [15:0] hold_cnt_reg;
   // Output follows the counter's next value, so it leaves a flip-flop yet tracks the count
   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         hold_cnt_reg <= '0;
         blocks_off_out <= 1'b0;
      end else if (clk_en_in) begin
         if (cmd == CMD_HARD_RESET) begin
            hold_cnt_reg <= 16'(HRST_HOLD_CYC);
            blocks_off_out <= (HRST_HOLD_CYC != 0);
         end else if (hold_cnt_reg != '0) begin
            hold_cnt_reg <= hold_cnt_reg - 1'b1;
            blocks_off_out <= (hold_cnt_reg != 16'h0001);
         end
      end
   end

   // ==========================================
   // Tone transmitter; forwarding starts after the incoming tone is complete
   logic [CNT_W-1:0] tx_runs_reg;
   logic [CNT_W-1:0] tx_couplet_reg;
   logic [CNT_W-1:0] tx_phase_reg;
   logic tx_neg_reg;
   logic tx_busy_reg;
   logic [CNT_W-1:0] req_runs;
   logic tx_on;

   always_comb begin
      req_runs = '0;
      if (cmd == CMD_WAKE || emit_wake_tone_cmd_in) req_runs = CNT_W'(TONE_WAKE_LEN);
      else if (cmd == CMD_SLEEP_EXIT || emit_sleep_exit_tone_cmd_in) req_runs = CNT_W'(TONE_S2A_LEN);
      else if (emit_shutdown_tone_cmd_in) req_runs = CNT_W'(TONE_SHDN_LEN);
      else if (emit_hard_reset_tone_cmd_in) req_runs = CNT_W'(TONE_HRST_LEN);
      else if (in_sleep_in && emit_heartbeat_in) req_runs = CNT_W'(TONE_HB_LEN);
      else if (in_sleep_in && emit_fault_tone_in) req_runs = CNT_W'(TONE_FAULT_LEN);
   end

   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         tx_busy_reg <= 1'b0;
         tx_runs_reg <= '0;
         tx_couplet_reg <= '0;
         tx_phase_reg <= '0;
         tx_neg_reg <= 1'b0;
      end else if (clk_en_in) begin
         if (!tx_busy_reg) begin
            if (req_runs != '0) begin
               tx_busy_reg <= 1'b1;
               tx_runs_reg <= req_runs;
               tx_couplet_reg <= '0;
               tx_phase_reg <= '0;
               tx_neg_reg <= 1'b0;
            end
         end else begin
            tx_phase_reg <= tx_phase_reg + 1'b1;
            // Transmit more couplets than detection needs, then a gap
            if (tx_phase_reg == CNT_W'(2 * COUPLET_HALF - 1)) begin
               tx_phase_reg <= '0;
               tx_couplet_reg <= tx_couplet_reg + 1'b1;
               if (tx_couplet_reg == CNT_W'(TONE_TX_P + 2)) begin
                  tx_couplet_reg <= '0;
                  tx_runs_reg <= tx_runs_reg - 1'b1;
                  if (tx_runs_reg == 8'h01) tx_busy_reg <= 1'b0;
               end
            end
         end
      end
   end

   assign tx_on = tx_busy_reg && tx_couplet_reg < CNT_W'(TONE_TX_P) && tx_phase_reg < CNT_W'(COUPLET_HALF);
   // Direction bit picks the outgoing port; registered so the link pins never glitch
   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         hi_pos_out <= 1'b0;
         hi_neg_out <= 1'b0;
         lo_pos_out <= 1'b0;
         lo_neg_out <= 1'b0;
      end else if (clk_en_in) begin
         hi_pos_out <= tx_on && !tx_neg_reg && dir_sel_in;
         hi_neg_out <= tx_on && tx_neg_reg && dir_sel_in;
         lo_pos_out <= tx_on && !tx_neg_reg && !dir_sel_in;
         lo_neg_out <= tx_on && tx_neg_reg && !dir_sel_in;
      end
   end
endmodule : ping_tone_device

// file: logic/ping_host.sv
`timescale 1ns/1ns

// Host side: shapes pings on the receive line (high, low, high)
module ping_host import ping_tone_pkg::*; (
   input wire logic sys_clk_in,
   input wire logic srst_in,
   input wire logic clk_en_in,
   input wire logic send_in,
   input wire logic [CNT_W-1:0] low_cycles_in,
   output logic rx_out,
   output logic busy_out
);
   // ==========================================
   // Drive low for the requested count, idle high otherwise
   logic [CNT_W-1:0] cnt_reg;
   // The line leaves a flip-flop that follows the counter's next value, so it never glitches
   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         cnt_reg <= '0;
         rx_out <= 1'b1;
      end else if (clk_en_in) begin
         if (cnt_reg == '0 && send_in) begin
            cnt_reg <= low_cycles_in;
            rx_out <= (low_cycles_in == '0);
         end else if (cnt_reg != '0) begin
            cnt_reg <= cnt_reg - 1'b1;
            rx_out <= (cnt_reg == CNT_W'(1));
         end
      end
   end
   assign busy_out = (cnt_reg != '0);
endmodule : ping_host

// file: verif/ping_tone_asserts.sv
`timescale 1ns/1ns
// ==========================================
// Checker on the host line and the base tone pins
module ping_tone_asserts (
   input wire logic sys_clk_in,
   input wire logic srst_in,
   input wire logic rx_line,
   input wire logic pos_couplet,
   input wire logic neg_couplet,
   input wire logic wake_pulse_out,
   input wire logic sleep_exit_pulse_out,
   input wire logic shutdown_pulse_out,
   input wire logic hard_reset_pulse_out,
   input wire logic uart_clear_pulse_out,
   input wire logic blocks_off_out
);
   logic [7:0] low_cnt;
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (srst_in);
   // Low time of the receive line; pings stay under 128 cycles so no wrap
   always_ff @(posedge sys_clk_in) begin
      if (srst_in || rx_line) begin
         low_cnt <= 8'h00;
      end else begin
         low_cnt <= low_cnt + 8'h01;
      end
   end
   // Whole class windows: this counter sees the same low cycles as the receiver
   a_wake_ping_class: assert property (
      $rose(rx_line) && low_cnt >= 8'h08 && low_cnt < 8'h10 |-> ##[1:2] wake_pulse_out)
      else $error("wake ping not classified");
   a_shdn_ping_class: assert property (
      $rose(rx_line) && low_cnt >= 8'h20 && low_cnt < 8'h40 |-> ##[1:2] shutdown_pulse_out)
      else $error("shutdown ping not classified");
   a_short_low_ignored: assert property ($rose(rx_line) && low_cnt < 8'h04 |-> !uart_clear_pulse_out [*4])
      else $error("short low taken as a ping");
   a_wake_tone_forward: assert property (wake_pulse_out |-> ##[1:100] (pos_couplet || neg_couplet))
      else $error("wake tone not forwarded");
   a_exit_tone_forward: assert property (sleep_exit_pulse_out |-> ##[1:100] (pos_couplet || neg_couplet))
      else $error("sleep exit tone not forwarded");
   a_shdn_not_forward: assert property (shutdown_pulse_out |-> (!pos_couplet && !neg_couplet) [*8])
      else $error("shutdown tone regenerated");
   a_hrst_not_forward: assert property (hard_reset_pulse_out |-> (!pos_couplet && !neg_couplet) [*8])
      else $error("hard reset tone forwarded");
   a_one_polarity: assert property (!(pos_couplet && neg_couplet))
      else $error("both couplet polarities at once");
   a_hrst_blocks_off: assert property (hard_reset_pulse_out |-> ##[0:2] blocks_off_out)
      else $error("blocks not held off");
   a_hold_stays: assert property ($rose(blocks_off_out) |-> blocks_off_out [*8])
      else $error("hold released early");
   a_pulse_single: assert property (hard_reset_pulse_out |=> !hard_reset_pulse_out)
      else $error("command pulse longer than a cycle");
   a_cmd_exclusive: assert property ($onehot0({wake_pulse_out, sleep_exit_pulse_out, shutdown_pulse_out,
      hard_reset_pulse_out}))
      else $error("two commands at once");
   c_wake: cover property (wake_pulse_out);
   c_shdn: cover property (shutdown_pulse_out);
   c_hold: cover property ($rose(blocks_off_out));
endmodule : ping_tone_asserts

// file: verif/ping_tone_detect_propagate_tb.sv
`timescale 1ns/1ns
module ping_tone_detect_propagate_tb;
   import ping_tone_pkg::*;
   logic sys_clk_in, srst_in, send, slp, dir, srx, hrx, boff;
   logic [CNT_W-1:0] low_n;
   logic [11:0] em;
   logic [3:0] b, s;
   logic [7:0] bp, sp, bs, ss;
   int error_cnt, cmp_count, cyc;
   int lens [11] = '{PING_CLR_MIN-1, PING_CLR_MIN, PING_WAKE_MIN-1, PING_WAKE_MIN, PING_S2A_MIN-1,
      PING_S2A_MIN, PING_SHDN_MIN-1, PING_SHDN_MIN, PING_HRST_MIN-1, PING_HRST_MIN, PING_MAX-1};
   logic [7:0] exb [11] = '{8'h00, 8'h10, 8'h10, 8'h01, 8'h01, 8'h12, 8'h12, 8'h04, 8'h04, 8'h08, 8'h08};
   logic [7:0] exs [11] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h02, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00};
   // ==========================================
   // Host, base and stack; tone pins cross-wired both ways, though only the stack decodes tones
   ping_host i_ping_host (.sys_clk_in, .srst_in, .clk_en_in(1'b1), .send_in(send), .low_cycles_in(low_n),
      .rx_out(hrx), .busy_out());
   ping_tone_device i_ping_tone_device (.sys_clk_in, .srst_in, .clk_en_in(1'b1), .is_base_in(1'b1),
      .in_sleep_in(slp), .in_active_in(!slp), .dir_sel_in(dir), .emit_wake_tone_cmd_in(em[0]),
      .emit_sleep_exit_tone_cmd_in(em[1]), .emit_shutdown_tone_cmd_in(em[2]), .emit_hard_reset_tone_cmd_in(em[3]),
      .emit_heartbeat_in(em[4]), .emit_fault_tone_in(em[5]), .hi_pos_in(s[1]), .hi_neg_in(s[0]),
      .lo_pos_in(s[3]), .lo_neg_in(s[2]), .rx_in(hrx), .hi_pos_out(b[3]), .hi_neg_out(b[2]), .lo_pos_out(b[1]),
      .lo_neg_out(b[0]), .wake_pulse_out(bp[0]), .sleep_exit_pulse_out(bp[1]), .shutdown_pulse_out(bp[2]),
      .hard_reset_pulse_out(bp[3]), .uart_clear_pulse_out(bp[4]), .digital_reset_pulse_out(bp[5]),
      .heartbeat_seen_pulse_out(bp[6]), .fault_tone_seen_pulse_out(bp[7]), .blocks_off_out(boff));
   ping_tone_device i_ping_tone_device_stack (.sys_clk_in, .srst_in, .clk_en_in(1'b1), .is_base_in(1'b0),
      .in_sleep_in(slp), .in_active_in(!slp), .dir_sel_in(dir), .emit_wake_tone_cmd_in(em[6]),
      .emit_sleep_exit_tone_cmd_in(em[7]), .emit_shutdown_tone_cmd_in(em[8]), .emit_hard_reset_tone_cmd_in(em[9]),
      .emit_heartbeat_in(em[10]), .emit_fault_tone_in(em[11]), .hi_pos_in(b[1]), .hi_neg_in(b[0]),
      .lo_pos_in(b[3]), .lo_neg_in(b[2]), .rx_in(srx), .hi_pos_out(s[3]), .hi_neg_out(s[2]), .lo_pos_out(s[1]),
      .lo_neg_out(s[0]), .wake_pulse_out(sp[0]), .sleep_exit_pulse_out(sp[1]), .shutdown_pulse_out(sp[2]),
      .hard_reset_pulse_out(sp[3]), .uart_clear_pulse_out(sp[4]), .digital_reset_pulse_out(sp[5]),
      .heartbeat_seen_pulse_out(sp[6]), .fault_tone_seen_pulse_out(sp[7]), .blocks_off_out());
   vertical_link_if i_link ();
   assign i_link.rx_line = hrx;
   assign i_link.pos_couplet = b[3] | b[1];
   assign i_link.neg_couplet = b[2] | b[0];
   assign i_link.tone_group_id = 1'b0;
   ping_tone_asserts i_ping_tone_asserts (.sys_clk_in, .srst_in, .rx_line(i_link.rx_line),
      .pos_couplet(i_link.pos_couplet), .neg_couplet(i_link.neg_couplet), .wake_pulse_out(bp[0]),
      .sleep_exit_pulse_out(bp[1]), .shutdown_pulse_out(bp[2]), .hard_reset_pulse_out(bp[3]),
      .uart_clear_pulse_out(bp[4]), .blocks_off_out(boff));
   // ==========================================
   // Clock and sticky record of every pulse seen
   initial begin
      sys_clk_in = 1'b0;
      forever #20 sys_clk_in = ~sys_clk_in;
   end
   always @(posedge sys_clk_in) begin
      bs = bs | bp;
      ss = ss | sp;
      cyc++;
      if (cyc == 15000) begin
         error_cnt++;
         tally_and_finish();
      end
   end
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error %0t: pulses %b expected %b", $time, got, exp);
      end
   endtask : check
   // One ping and/or tone request, then a long quiet gap so tones finish
   task automatic run(input int n, input logic [11:0] e, input logic [7:0] eb, input logic [7:0] es);
      @(negedge sys_clk_in);
      bs = 8'h00;
      ss = 8'h00;
      low_n = n[CNT_W-1:0];
      send = (n != 0);
      em = e;
      @(negedge sys_clk_in);
      send = 1'b0;
      em = 12'h000;
      repeat (400) @(negedge sys_clk_in);
      check(bs & (slp ? 8'hDF : 8'hFF), eb);
      check(ss & 8'hCF, es);
   endtask : run
   task automatic tally_and_finish();
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : tally_and_finish
   // ==========================================
   // Main sequence
   initial begin
      srst_in = 1'b1;
      {send, low_n, em, slp, dir, srx, bs, ss} = '0;
      {slp, dir, srx} = 3'h7;
      repeat (16) @(negedge sys_clk_in);
      srst_in = 1'b0;
      for (int i = 0; i < 11; i++) run(lens[i], 12'h000, exb[i], exs[i]);
      for (int d = 0; d < 2; d++) begin
         dir = d[0];
         for (int k = 0; k < 6; k++) run(0, 12'h001 << k, 8'h00, (k < 4 ? 8'h01 : 8'h04) << k);
      end
      run(0, 12'h040, 8'h00, 8'h00);
      srx = 1'b0;
      run(0, 12'h000, 8'h00, 8'h00);
      srx = 1'b1;
      run(0, 12'h000, 8'h00, 8'h00);
      slp = 1'b0;
      run(PING_WAKE_MIN, 12'h000, 8'h21, 8'h01);
      run(0, 12'h010, 8'h00, 8'h00);
      tally_and_finish();
   end
endmodule : ping_tone_detect_propagate_tb
